// File: rtl/pmt_pkg.sv
// Purpose: constants for power mode, timer and interrupt control
// Assumes: register index addressing, 8-bit index
// Notes: one name per register index and flag position; field positions reuse numbers across registers
package pmt_pkg;
  localparam int CLK_NS = 50;
  localparam int PD_MIN_NS = 10000;
  localparam int PD_MIN_CYC = (PD_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int PDW = 8;
  localparam logic [PDW-1:0] PD_LIM = PDW'(PD_MIN_CYC);
  localparam int NTMR = 3;
  localparam int NFLG = 8;
  localparam int DIVW = 8;

  // register indices
  localparam logic [7:0] A_IRQ_EN = 8'h01;
  localparam logic [7:0] A_IRQ_STAT = 8'h02;
  localparam logic [7:0] A_IRQ_CLR = 8'h03;
  localparam logic [7:0] A_PAD_DIR = 8'h05;
  localparam logic [7:0] A_PAD_OUT = 8'h07;
  localparam logic [7:0] A_WAKE_CFG = 8'h0A;
  localparam logic [7:0] A_TCFG = 8'h10;
  localparam logic [7:0] A_TRLD = 8'h13;
  localparam logic [7:0] A_TVAL = 8'h16;
  localparam logic [7:0] A_TEMP_CTL = 8'h25;
  localparam logic [7:0] A_DIST_CTL = 8'h28;

  // status flag positions
  localparam int F_IDLE = 0;
  localparam int F_TMR0 = 1;
  localparam int F_OTEMP = 4;
  localparam int F_CARD = 5;
  localparam int F_PARAM = 6;
  localparam int F_HV = 7;
  localparam logic [NFLG-1:0] NMI_MASK = 8'hE0;

  // field positions
  localparam int TC_PRE = 0;
  localparam int TC_SEL = 3;
  localparam int TC_RLD = 6;
  localparam int TC_ARM = 7;
  localparam int WK_TMR = 0;
  localparam int WK_RF = 1;
  localparam int DC_ON = 0;

  // over-temperature limits in degrees
  localparam logic [7:0] T_LIM0 = 8'h55;
  localparam logic [7:0] T_LIM1 = 8'h73;
  localparam logic [7:0] T_LIM2 = 8'h7D;
  localparam logic [7:0] T_LIM3 = 8'h87;

  typedef enum logic [1:0] {
    PMT_PWRDN = 2'b00,
    PMT_START = 2'b01,
    PMT_RUN = 2'b10,
    PMT_STBY = 2'b11
  } pmt_state_t;
endpackage

// File: rtl/pmt_ctrl.sv
// Purpose: power modes, three timers and interrupt status for a reader
// Assumes: mclk 20 MHz, inputs synchronous, host commands pre-decoded
// Notes: registers addressed by 8-bit index
`timescale 1ns/1ns
module pmt_ctrl
  import pmt_pkg::*;
#(
  parameter int STARTUP_CYC = 64,
  parameter int TW = 20
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic pdn_pin_n,
  input wire logic host_cmd_valid,
  input wire logic host_cmd_write,
  input wire logic [7:0] host_cmd_addr,
  input wire logic [31:0] host_cmd_wdata,
  output logic host_cmd_ready,
  output logic [31:0] host_rdata,
  input wire logic standby_req,
  input wire logic host_activity,
  input wire logic host_io_supply,
  input wire logic rf_level_det,
  input wire logic [7:0] temp_celsius,
  input wire logic [5:0] rf_evt,
  input wire logic disturbance_evt,
  input wire logic crypto_auth_busy,
  input wire logic card_detect_interrupt,
  input wire logic param_fault_evt,
  input wire logic high_voltage_fault_interrupt,
  input wire logic nv_clear_on_read,
  input wire logic nv_irq_active_high,
  output logic regulators_lowpower,
  output logic osc_lowpower,
  output logic input_clamp,
  output logic pulldown_en,
  output logic current_sink_lowpower,
  output logic rf_field_off,
  output logic irq_o,
  output logic irq_oe,
  output logic busy_o,
  output logic busy_oe,
  output logic [31:0] pad_o,
  output logic [31:0] pad_oe
);

  // ------------------------------------------------------------
  // power mode sequencing
  // ------------------------------------------------------------
  pmt_state_t state_r;
  logic [PDW-1:0] pd_cnt_r;
  logic [15:0] su_cnt_r;
  logic pd_hold;
  logic wake;
  logic clr_vol;
  logic [NTMR-1:0] texp;
  logic [31:0] wake_cfg_r;

  assign pd_hold = (pd_cnt_r == PD_LIM);
  assign wake = wake_cfg_r[WK_TMR] & (|texp) | wake_cfg_r[WK_RF] & rf_level_det
    | ~host_io_supply | ~pdn_pin_n | host_activity;
  // volatile state is dropped on the way out of standby; timers keep
  // counting inside standby so a timer wake remains possible
  assign clr_vol = (state_r == PMT_STBY) & wake;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pd_cnt_r <= '0;
    end else if (pdn_pin_n) begin
      pd_cnt_r <= '0;
    end else if (!pd_hold) begin
      pd_cnt_r <= pd_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= PMT_START;
      su_cnt_r <= '0;
    end else if (pd_hold) begin
      state_r <= PMT_PWRDN;
      su_cnt_r <= '0;
    end else begin
      case (state_r)
        PMT_PWRDN: begin
          if (pdn_pin_n) begin
            state_r <= PMT_START;
          end
        end
        PMT_START: begin
          if (su_cnt_r == 16'(STARTUP_CYC - 1)) begin
            state_r <= PMT_RUN;
            su_cnt_r <= '0;
          end else begin
            su_cnt_r <= su_cnt_r + 1'b1;
          end
        end
        PMT_RUN: begin
          if (standby_req) begin
            state_r <= PMT_STBY;
          end
        end
        PMT_STBY: begin
          if (wake) begin
            state_r <= PMT_START;
          end
        end
        default: state_r <= PMT_START;
      endcase
    end
  end

  logic idle_evt;
  assign idle_evt = (state_r == PMT_START) & (su_cnt_r == 16'(STARTUP_CYC - 1)) & ~pd_hold;

  // ------------------------------------------------------------
  // pad control
  // ------------------------------------------------------------
  logic [31:0] pad_dir_r;
  logic [31:0] pad_out_r;
  logic [31:0] temp_ctl_r;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      regulators_lowpower <= 1'b0;
      osc_lowpower <= 1'b0;
      input_clamp <= 1'b0;
      pulldown_en <= 1'b0;
      current_sink_lowpower <= 1'b0;
    end else begin
      regulators_lowpower <= ~pdn_pin_n;
      osc_lowpower <= ~pdn_pin_n;
      input_clamp <= ~pdn_pin_n;
      pulldown_en <= ~pdn_pin_n;
      current_sink_lowpower <= (state_r == PMT_STBY);
    end
  end

  // standby keeps pad levels since their registers are retained
  assign pad_o = pad_out_r;
  assign pad_oe = input_clamp ? 32'h0000_0000 : pad_dir_r;
  assign irq_oe = ~input_clamp;
  assign busy_oe = ~input_clamp;
  assign host_cmd_ready = (state_r == PMT_RUN);

  // ------------------------------------------------------------
  // host register access
  // ------------------------------------------------------------
  logic wr;
  logic rd;
  logic [31:0] irq_en_r;
  logic [31:0] dist_ctl_r;
  logic [NFLG-1:0] flags_r;
  logic [NTMR*8-1:0] tcfg_all;
  logic [NTMR*TW-1:0] trld_all;
  logic [NTMR*TW-1:0] tcnt_all;
  logic [31:0] rdata_nxt;

  assign wr = host_cmd_valid & host_cmd_write & host_cmd_ready;
  assign rd = host_cmd_valid & ~host_cmd_write & host_cmd_ready;

  // retained registers survive standby, only hard power-down clears them
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pad_dir_r <= '0;
      pad_out_r <= '0;
      temp_ctl_r <= '0;
    end else if (pd_hold) begin
      pad_dir_r <= '0;
      pad_out_r <= '0;
      temp_ctl_r <= '0;
    end else if (wr) begin
      if (host_cmd_addr == A_PAD_DIR) pad_dir_r <= host_cmd_wdata;
      if (host_cmd_addr == A_PAD_OUT) pad_out_r <= host_cmd_wdata;
      if (host_cmd_addr == A_TEMP_CTL) temp_ctl_r <= host_cmd_wdata;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_en_r <= '0;
      dist_ctl_r <= '0;
      wake_cfg_r <= '0;
    end else if (pd_hold | clr_vol) begin
      irq_en_r <= '0;
      dist_ctl_r <= '0;
      wake_cfg_r <= '0;
    end else if (wr) begin
      if (host_cmd_addr == A_IRQ_EN) irq_en_r <= host_cmd_wdata;
      if (host_cmd_addr == A_DIST_CTL) dist_ctl_r <= host_cmd_wdata;
      if (host_cmd_addr == A_WAKE_CFG) wake_cfg_r <= host_cmd_wdata;
    end
  end

  always_comb begin
    rdata_nxt = '0;
    case (host_cmd_addr)
      A_IRQ_EN: rdata_nxt = irq_en_r;
      A_IRQ_STAT: rdata_nxt = {24'h00_0000, flags_r};
      A_PAD_DIR: rdata_nxt = pad_dir_r;
      A_PAD_OUT: rdata_nxt = pad_out_r;
      A_WAKE_CFG: rdata_nxt = wake_cfg_r;
      A_TEMP_CTL: rdata_nxt = temp_ctl_r;
      A_DIST_CTL: rdata_nxt = dist_ctl_r;
      default: begin
        for (int k = 0; k < NTMR; k++) begin
          if (host_cmd_addr == A_TCFG + 8'(k)) rdata_nxt = {24'h00_0000, tcfg_all[k*8 +: 8]};
          if (host_cmd_addr == A_TRLD + 8'(k)) rdata_nxt = 32'(trld_all[k*TW +: TW]);
          if (host_cmd_addr == A_TVAL + 8'(k)) rdata_nxt = 32'(tcnt_all[k*TW +: TW]);
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      host_rdata <= '0;
    end else if (rd) begin
      host_rdata <= rdata_nxt;
    end
  end

  // ------------------------------------------------------------
  // temperature supervision
  // ------------------------------------------------------------
  logic [7:0] t_lim;
  logic otemp;

  always_comb begin
    case (temp_ctl_r[1:0])
      2'b00: t_lim = T_LIM0;
      2'b01: t_lim = T_LIM1;
      2'b10: t_lim = T_LIM2;
      default: t_lim = T_LIM3;
    endcase
  end
  assign otemp = (temp_celsius > t_lim);

  // ------------------------------------------------------------
  // general-purpose timers
  // ------------------------------------------------------------
  logic [DIVW-1:0] div_r;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  for (genvar i = 0; i < NTMR; i++) begin : g_tmr
    logic [7:0] cfg_r;
    logic [TW-1:0] rld_r;
    logic [TW-1:0] cnt_r;
    logic run_r;
    logic wr_ok;
    logic cfg_wr;
    logic [DIVW-1:0] msk;
    logic tick;
    logic [7:0] evt;
    logic start;
    logic restart;
    logic [7:0] cfg_cur;

    // authentication owns timer two, host writes are dropped meanwhile
    assign wr_ok = wr & ~((i == 2) & crypto_auth_busy);
    assign cfg_wr = wr_ok & (host_cmd_addr == A_TCFG + 8'(i));
    assign msk = DIVW'((2 << cfg_r[TC_PRE +: 3]) - 1);
    assign tick = ((div_r & msk) == msk);
    assign evt = {1'b0, rf_evt, cfg_wr};
    // the arming write itself may start the timer, so look at the new value
    assign cfg_cur = cfg_wr ? host_cmd_wdata[7:0] : cfg_r;
    assign start = cfg_cur[TC_ARM] & evt[cfg_cur[TC_SEL +: 3]];
    assign restart = (i == 1) & dist_ctl_r[DC_ON] & disturbance_evt;
    assign texp[i] = run_r & tick & (cnt_r == '0);

    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        cfg_r <= '0;
        rld_r <= '0;
      end else if (pd_hold | clr_vol) begin
        cfg_r <= '0;
        rld_r <= '0;
      end else begin
        if (cfg_wr) cfg_r <= host_cmd_wdata[7:0];
        if (wr_ok & (host_cmd_addr == A_TRLD + 8'(i))) rld_r <= host_cmd_wdata[TW-1:0];
      end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        cnt_r <= '0;
        run_r <= 1'b0;
      end else if (pd_hold | clr_vol) begin
        cnt_r <= '0;
        run_r <= 1'b0;
      end else if (start | restart) begin
        cnt_r <= rld_r;
        run_r <= 1'b1;
      end else if (run_r & tick) begin
        if (cnt_r == '0) begin
          cnt_r <= rld_r;
          run_r <= cfg_r[TC_RLD];
        end else begin
          cnt_r <= cnt_r - 1'b1;
        end
      end
    end

    assign tcfg_all[i*8 +: 8] = cfg_r;
    assign trld_all[i*TW +: TW] = rld_r;
    assign tcnt_all[i*TW +: TW] = cnt_r;
  end

  // ------------------------------------------------------------
  // interrupt status and pin
  // ------------------------------------------------------------
  logic [NFLG-1:0] fset;
  logic [NFLG-1:0] fclr;
  logic pend;

  always_comb begin
    fset = '0;
    fset[F_IDLE] = idle_evt;
    fset[F_TMR0 +: NTMR] = texp;
    fset[F_OTEMP] = otemp;
    fset[F_CARD] = card_detect_interrupt;
    fset[F_PARAM] = param_fault_evt;
    fset[F_HV] = high_voltage_fault_interrupt;
  end

  always_comb begin
    fclr = '0;
    if (wr & (host_cmd_addr == A_IRQ_CLR) & ~nv_clear_on_read) begin
      fclr = host_cmd_wdata[NFLG-1:0];
    end
    if (rd & (host_cmd_addr == A_IRQ_STAT) & nv_clear_on_read) begin
      fclr = '1;
    end
    if (pd_hold | clr_vol) begin
      fclr = '1;
    end
  end

  // set wins over clear so no event is lost; mask never gates setting
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      flags_r <= '0;
    end else begin
      flags_r <= (flags_r & ~fclr) | fset;
    end
  end

  assign pend = |(flags_r & (irq_en_r[NFLG-1:0] | NMI_MASK));

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_o <= 1'b0;
      busy_o <= 1'b1;
      rf_field_off <= 1'b0;
    end else begin
      irq_o <= nv_irq_active_high ? pend : ~pend;
      busy_o <= (state_r != PMT_RUN);
      rf_field_off <= flags_r[F_OTEMP];
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  a_pd_entry: assert property (pd_hold |=> state_r == PMT_PWRDN)
    else $error("power-down not entered");
  a_pd_short: assert property (pdn_pin_n ##1 !pdn_pin_n [*8] |-> state_r != PMT_PWRDN
    || $past(state_r, 8) == PMT_PWRDN)
    else $error("short pulse reset the core");
  a_lowpwr: assert property (!pdn_pin_n |=> regulators_lowpower && osc_lowpower)
    else $error("low power not applied");
  a_clamp: assert property (!pdn_pin_n |=> input_clamp)
    else $error("inputs not clamped");
  a_pins_hiz: assert property (!pdn_pin_n |=> pulldown_en && !irq_oe && pad_oe == '0)
    else $error("pins driven in power-down");
  a_leave_pd: assert property (state_r == PMT_PWRDN && pdn_pin_n && !pd_hold
    |=> state_r == PMT_START)
    else $error("start-up not begun");
  a_idle_flag: assert property (idle_evt |=> flags_r[F_IDLE] && host_cmd_ready)
    else $error("idle flag missing");
  a_stby_in: assert property (state_r == PMT_RUN && standby_req && !pd_hold
    |=> state_r == PMT_STBY && current_sink_lowpower == 1'b0 ##1 current_sink_lowpower)
    else $error("standby not entered");
  a_stby_wake: assert property (state_r == PMT_STBY && host_activity && !pd_hold
    |=> state_r == PMT_START)
    else $error("host activity did not wake");
  a_wake_clear: assert property (clr_vol |=> irq_en_r == '0 && wake_cfg_r == '0
    && pad_dir_r == $past(pad_dir_r))
    else $error("standby retention wrong");
  a_otemp: assert property (otemp && !pd_hold |=> flags_r[F_OTEMP] ##1 rf_field_off)
    else $error("overtemperature not handled");
  a_nmi_pin: assert property (flags_r[F_HV]
    |=> irq_o == $past(nv_irq_active_high))
    else $error("fault not on pin");
  a_flag_set: assert property (card_detect_interrupt && !pd_hold && !clr_vol
    |=> flags_r[F_CARD])
    else $error("flag not set");
  a_tmr_exp: assert property (texp[0] |=> flags_r[F_TMR0])
    else $error("timer expiry lost");

  c_stby_cycle: cover property (state_r == PMT_STBY ##[1:50] state_r == PMT_RUN);
  c_tmr_exp: cover property (texp[1]);
  c_otemp: cover property (otemp ##2 rf_field_off);
  c_pd: cover property (state_r == PMT_PWRDN ##1 state_r == PMT_START);

endmodule

// File: testbench/pmt_host_model.sv
// Purpose: host side model, register commands and the power-down pin
// Assumes: commands are issued only while host_cmd_ready is high
// Notes: every drive changes at the falling edge of mclk
`timescale 1ns/1ns
module pmt_host_model (
  input wire logic mclk,
  input wire logic host_cmd_ready,
  input wire logic [31:0] host_rdata,
  output logic host_cmd_valid,
  output logic host_cmd_write,
  output logic [7:0] host_cmd_addr,
  output logic [31:0] host_cmd_wdata,
  output logic pdn_pin_n
);
  initial begin
    host_cmd_valid = 1'b0;
    host_cmd_write = 1'b0;
    host_cmd_addr = 8'h00;
    host_cmd_wdata = 32'h0000_0000;
    pdn_pin_n = 1'b1;
  end

  // one-cycle strobe, qualifiers held until the taking edge has passed
  task automatic cmd(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(negedge mclk);
    host_cmd_valid = 1'b1;
    host_cmd_write = wr;
    host_cmd_addr = a;
    host_cmd_wdata = d;
    @(negedge mclk);
    host_cmd_valid = 1'b0;
    // scramble released data so stale values never look valid
    host_cmd_wdata = ~d;
    host_cmd_addr = ~a;
    q = host_rdata;
  endtask

  task automatic pin_low();
    @(negedge mclk);
    pdn_pin_n = 1'b0;
  endtask

  task automatic pin_high();
    @(negedge mclk);
    pdn_pin_n = 1'b1;
  endtask
endmodule

// File: testbench/pmt_ctrl_tb_top.sv
// Purpose: self-checking bench for power modes, timers and interrupts
// Assumes: STARTUP_CYC shortened to 4, mclk 20 MHz
// Notes: random values from a fixed seed, corner cases written by hand
`timescale 1ns/1ns
module pmt_ctrl_tb_top;
  import pmt_pkg::*;
  localparam int SU = 4;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic pdn_pin_n, host_cmd_valid, host_cmd_write, host_cmd_ready;
  logic [7:0] host_cmd_addr;
  logic [31:0] host_cmd_wdata, host_rdata, pad_o, pad_oe, q, v;
  logic standby_req = 1'b0;
  logic host_activity = 1'b0;
  logic host_io_supply = 1'b1;
  logic [7:0] temp_celsius = 8'h00;
  logic crypto_auth_busy = 1'b0;
  logic card_evt = 1'b0;
  logic param_evt = 1'b0;
  logic nv_clear_on_read = 1'b0;
  logic nv_irq_active_high = 1'b1;
  logic rf_on = 1'b0, dist_evt = 1'b0, hv_evt = 1'b0, rf_lvl = 1'b0;
  logic regulators_lowpower, osc_lowpower, input_clamp, pulldown_en;
  logic current_sink_lowpower, rf_field_off, irq_o, irq_oe, busy_o, busy_oe;
  int n_mismatch = 0;
  int tests_run = 0;
  int p;

  always #25 mclk = ~mclk;

  pmt_host_model host (.mclk(mclk), .host_cmd_ready(host_cmd_ready),
    .host_rdata(host_rdata), .host_cmd_valid(host_cmd_valid),
    .host_cmd_write(host_cmd_write), .host_cmd_addr(host_cmd_addr),
    .host_cmd_wdata(host_cmd_wdata), .pdn_pin_n(pdn_pin_n));

  pmt_ctrl #(.STARTUP_CYC(SU), .TW(20)) uut (.mclk(mclk), .arst_n(arst_n),
    .pdn_pin_n(pdn_pin_n), .host_cmd_valid(host_cmd_valid),
    .host_cmd_write(host_cmd_write), .host_cmd_addr(host_cmd_addr),
    .host_cmd_wdata(host_cmd_wdata), .host_cmd_ready(host_cmd_ready),
    .host_rdata(host_rdata), .standby_req(standby_req), .host_activity(host_activity),
    .host_io_supply(host_io_supply), .rf_level_det(rf_lvl), .temp_celsius(temp_celsius),
    .rf_evt({5'h00, rf_on}), .disturbance_evt(dist_evt), .crypto_auth_busy(crypto_auth_busy),
    .card_detect_interrupt(card_evt), .param_fault_evt(param_evt),
    .high_voltage_fault_interrupt(hv_evt), .nv_clear_on_read(nv_clear_on_read),
    .nv_irq_active_high(nv_irq_active_high), .regulators_lowpower(regulators_lowpower),
    .osc_lowpower(osc_lowpower), .input_clamp(input_clamp), .pulldown_en(pulldown_en),
    .current_sink_lowpower(current_sink_lowpower), .rf_field_off(rf_field_off),
    .irq_o(irq_o), .irq_oe(irq_oe), .busy_o(busy_o), .busy_oe(busy_oe),
    .pad_o(pad_o), .pad_oe(pad_oe));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    host.cmd(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [7:0] a);
    host.cmd(1'b0, a, 32'h0000_0000, q);
  endtask

  // bounded wait, a hang is reported and ends the run
  task automatic wait_ready();
    int i;
    for (i = 0; i < 400 && host_cmd_ready !== 1'b1; i++) begin
      @(negedge mclk);
    end
    if (host_cmd_ready !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH ready expected 1 seen %b", host_cmd_ready);
      test_done();
    end
  endtask

  task automatic pulse(ref logic s);
    @(negedge mclk);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
  endtask

  function automatic logic [7:0] lim(input int k);
    case (k)
      0: lim = T_LIM0;
      1: lim = T_LIM1;
      2: lim = T_LIM2;
      default: lim = T_LIM3;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(70844));
    cyc(10);
    arst_n = 1'b1;
    @(negedge mclk);
    chk("busy_startup", {31'h0, busy_o}, 32'h1);
    wait_ready();
    rd(A_IRQ_STAT);
    chk("idle_flag", {31'h0, q[F_IDLE]}, 32'h1);
    wr(A_IRQ_CLR, 32'h0000_00FF);
    wr(A_IRQ_EN, 32'h0000_0000);
    pulse(card_evt);
    cyc(2);
    chk("irq_nmi", {31'h0, irq_o}, 32'h1);
    rd(A_IRQ_STAT);
    chk("stat_card", q, 32'h0000_0020);
    wr(A_IRQ_CLR, 32'h0000_00FF);
    cyc(2);
    chk("irq_cleared", {31'h0, irq_o}, 32'h0);
    rd(8'h3F);
    chk("unmapped", q, 32'h0000_0000);
    // timer0 at three prescale rates, reload 4, no auto reload
    for (p = 0; p < 3; p++) begin
      wr(A_TRLD, 32'h0000_0004);
      wr(A_TCFG, 32'h0000_0080 | p);
      cyc((3 << (p + 1)) - 3);
      rd(A_IRQ_STAT);
      chk("tmr_early", {31'h0, q[F_TMR0]}, 32'h0);
      cyc((4 << (p + 1)) + 4);
      rd(A_IRQ_STAT);
      chk("tmr_expired", {31'h0, q[F_TMR0]}, 32'h1);
      chk("irq_masked", {31'h0, irq_o}, 32'h0);
      wr(A_IRQ_EN, 32'h0000_0002);
      cyc(3);
      chk("irq_routed", {31'h0, irq_o}, 32'h1);
      wr(A_IRQ_CLR, 32'h0000_0002);
      cyc(3);
      chk("irq_tmr_clr", {31'h0, irq_o}, 32'h0);
      wr(A_IRQ_EN, 32'h0000_0000);
    end
    // limit boundary: one below, at or one above, picked at random for each limit
    for (p = 0; p < 4; p++) begin
      temp_celsius = 8'h00;
      wr(A_TEMP_CTL, p);
      cyc(2);
      wr(A_IRQ_CLR, 32'h0000_00FF);
      temp_celsius = lim(p) + 8'($urandom % 3) - 8'h01;
      cyc(3);
      rd(A_IRQ_STAT);
      chk("otemp_flag", {31'h0, q[F_OTEMP]}, {31'h0, temp_celsius > lim(p)});
      chk("field_off", {31'h0, rf_field_off}, {31'h0, temp_celsius > lim(p)});
    end
    temp_celsius = 8'h00;
    cyc(2);
    wr(A_IRQ_CLR, 32'h0000_00FF);
    crypto_auth_busy = 1'b1;
    wr(A_TRLD + 8'h02, 32'h0000_0005);
    rd(A_TRLD + 8'h02);
    chk("t2_locked", q, 32'h0000_0000);
    crypto_auth_busy = 1'b0;
    wr(A_TRLD + 8'h02, 32'h0000_0005);
    rd(A_TRLD + 8'h02);
    chk("t2_free", q, 32'h0000_0005);
    // start on rf field on, then disturbance restart of timer one
    wr(A_TCFG, 32'h0000_0088);
    cyc(30);
    rd(A_IRQ_STAT);
    chk("rf_wait", {31'h0, q[F_TMR0]}, 32'h0);
    pulse(rf_on);
    cyc(30);
    rd(A_IRQ_STAT);
    chk("rf_start", {31'h0, q[F_TMR0]}, 32'h1);
    wr(A_DIST_CTL, 32'h0000_0001);
    wr(A_TRLD + 8'h01, 32'h0000_0010);
    pulse(dist_evt);
    rd(A_TVAL + 8'h01);
    chk("t1_restart", {31'h0, q != 32'h0}, 32'h1);
    cyc(40);
    rd(A_IRQ_STAT);
    chk("t1_expired", {31'h0, q[F_TMR0 + 1]}, 32'h1);
    wr(A_IRQ_CLR, 32'h0000_00FF);
    nv_clear_on_read = 1'b1;
    pulse(param_evt);
    cyc(1);
    rd(A_IRQ_STAT);
    chk("param_flag", {31'h0, q[F_PARAM]}, 32'h1);
    rd(A_IRQ_STAT);
    chk("read_clears", q, 32'h0000_0000);
    nv_clear_on_read = 1'b0;
    nv_irq_active_high = 1'b0;
    cyc(3);
    chk("irq_polarity", {31'h0, irq_o}, 32'h1);
    pulse(hv_evt);
    cyc(2);
    chk("irq_hv_low", {31'h0, irq_o}, 32'h0);
    wr(A_IRQ_CLR, 32'h0000_00FF);
    cyc(2);
    chk("irq_hv_gone", {31'h0, irq_o}, 32'h1);
    nv_irq_active_high = 1'b1;
    // standby, retained registers, wake by host activity, then by supply loss, then by rf level
    v = $urandom;
    wr(A_PAD_DIR, v);
    wr(A_PAD_OUT, ~v);
    wr(A_TEMP_CTL, 32'h0000_0003);
    wr(A_IRQ_EN, 32'h0000_00FF);
    pulse(standby_req);
    cyc(2);
    chk("sink_lowpower", {31'h0, current_sink_lowpower}, 32'h1);
    chk("pads_hold", pad_oe, v);
    chk("pads_level", pad_o, ~v);
    pulse(host_activity);
    wait_ready();
    rd(A_PAD_DIR);
    chk("kept_dir", q, v);
    rd(A_PAD_OUT);
    chk("kept_out", q, ~v);
    rd(A_TEMP_CTL);
    chk("kept_temp", q, 32'h0000_0003);
    rd(A_IRQ_EN);
    chk("lost_irq_en", q, 32'h0000_0000);
    rd(A_IRQ_STAT);
    chk("wake_idle", {31'h0, q[F_IDLE]}, 32'h1);
    pulse(standby_req);
    cyc(2);
    @(negedge mclk);
    host_io_supply = 1'b0;
    @(negedge mclk);
    host_io_supply = 1'b1;
    chk("supply_busy", {31'h0, busy_o}, 32'h1);
    wait_ready();
    rd(A_PAD_DIR);
    chk("supply_wake", q, v);
    wr(A_WAKE_CFG, 32'h0000_0002);
    pulse(standby_req);
    cyc(2);
    pulse(rf_lvl);
    wait_ready();
    rd(A_WAKE_CFG);
    chk("rf_lvl_wake", q, 32'h0000_0000);
    // short low pulse keeps state, long one is a hard power-down
    host.pin_low();
    cyc(PD_MIN_CYC - 20);
    chk("clamp", {31'h0, input_clamp}, 32'h1);
    chk("lowpower", {30'h0, regulators_lowpower, osc_lowpower}, 32'h3);
    chk("pulldown", {29'h0, pulldown_en, irq_oe, busy_oe}, 32'h4);
    chk("pads_hiz", pad_oe, 32'h0000_0000);
    host.pin_high();
    cyc(3);
    rd(A_PAD_DIR);
    chk("short_pulse", q, v);
    host.pin_low();
    cyc(PD_MIN_CYC + 20);
    host.pin_high();
    wait_ready();
    rd(A_PAD_DIR);
    chk("pd_reset", q, 32'h0000_0000);
    test_done();
  end
endmodule
